/* File: sst_ctl.sv */
/*
  Transmit data FIFO and the transmitter control block of a synchronous
  serial line: control/status register, write-only data buffer, sync and
  line parameter registers, serial shifter and interrupt request logic.
  Assumes a register port with one-cycle read and write strobes and a
  transmit bit tick from the modem clock, synchronous to sys_clk.
*/
// Notes on behaviour
// - Transmit-done flag raises transmitter request while its enable is set.
// - Fill-sent flag raises transmitter request while its own enable is set.
// - Enables, send, half duplex, break are read/write, cleared by any reset.
// - Send arms the transmitter; output starts with the first buffered character.
// - Dropping send finishes the current character, then idles at mark.
// - Half duplex with send set disables the receiver.
// - Break holds the serial output low.
// - Buffer takes 5 to 8 bit characters, right justified in low byte.
// - Parity bit is generated and appended by the transmitter.
// - Data buffer is write-only and resets to all ones.
// - Separate receiver and transmitter vectors; receiver wins when both request.
// - Receiver request from receive-done or modem change, each with enable.
// - Bus request level defaults to five, set by a parameter.
// - Vector addresses are parameters, not fixed.
// - Sync register resets to ones and serves as fill character.
// - No new character at end of frame sends sync and flags fill.
// - Done flag set by reset and on first bit out, cleared by load.
// - Fill-sent flag is read-only, set on fill, cleared by status read.
`include "sst_map.svh"

// ****************************************
// FIFO
// ****************************************
module sst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SST_FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } sst_fifo_state_t;

  sst_fifo_state_t st;
  sst_fifo_state_t next_st;
  logic            push;
  logic            pop;

  assign in_ready  = (st.cnt != FULL_CNT);
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = (st.wp == LAST_PTR) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == LAST_PTR) ? '0 : st.rp + 1'b1;
    end
    // Simultaneous push and pop keep the count
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    if (flush) begin
      next_st = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // sst_fifo

// ****************************************
// Transmitter control
// ****************************************
module sst_ctl #(
  parameter logic [2:0] BUS_REQUEST_LEVEL = `SST_BR_LEVEL,
  parameter logic [7:0] RX_VECTOR         = `SST_RX_VECTOR,
  parameter logic [7:0] TX_VECTOR         = `SST_TX_VECTOR,
  parameter int         FIFO_DEPTH        = `SST_FIFO_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [1:0]  reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output      logic [15:0] reg_rdata,
  output      logic        tx_buf_ready,
  input  wire logic        tx_bit_tick,
  output      logic        serial_out,
  output      logic        rx_disable,
  input  wire logic        rx_done_flag,
  input  wire logic        rx_ready_irq_enable,
  input  wire logic        modem_status_change_flag,
  input  wire logic        modem_change_irq_enable,
  input  wire logic        irq_ack,
  output      logic        rx_irq_req,
  output      logic        tx_irq_req,
  output      logic [7:0]  irq_vector,
  output      logic [2:0]  bus_request_level
);
  // Reset image; data buffer and sync character come up as ones
  localparam sst_pkg::sst_state_t RST_ST = '{
    tx_done:        1'b1,
    tx_data_buffer: `SST_BYTE_ONES,
    sync_char:      `SST_BYTE_ONES,
    fsm:            sst_pkg::SST_IDLE,
    shreg:          '1,
    serial_out:     1'b1,
    default:        '0
  };

  sst_pkg::sst_state_t st;
  sst_pkg::sst_state_t next_st;
  logic                wr_csr;
  logic                wr_dbuf;
  logic                rd_csr;
  logic                soft_clear;
  logic                fifo_valid;
  logic                fifo_pop;
  logic [7:0]          fifo_data;
  logic                rx_cond;
  logic                tx_cond;

  // ****************************************
  // Frame builder
  // ****************************************
  // Unused high data bits are masked so parity covers only real bits
  function automatic logic [8:0] sst_frame(
    input logic [7:0] d,
    input logic [1:0] len,
    input logic       pe,
    input logic       odd
  );
    logic [7:0] m;
    logic [8:0] f;
    logic [3:0] pos;
    m   = d & (`SST_BYTE_ONES >> (`SST_LEN_MAX_CODE - len));
    f   = {1'b1, m};
    pos = `SST_MIN_CHAR_LEN + {2'b00, len};
    if (pe) begin
      f[pos] = (^m) ^ odd;
    end
    return f;
  endfunction

  function automatic logic [3:0] sst_bits(input logic [1:0] len, input logic pe);
    return `SST_MIN_CHAR_LEN + {2'b00, len} + {3'b000, pe};
  endfunction

  // ****************************************
  // Register strobes
  // ****************************************
  assign wr_csr     = reg_wr && (reg_sel == `SST_SEL_CSR);
  assign wr_dbuf    = reg_wr && (reg_sel == `SST_SEL_DBUF);
  assign rd_csr     = reg_rd && (reg_sel == `SST_SEL_CSR);
  assign soft_clear = wr_csr && reg_wdata[`SST_CSR_SOFT_CLR];

  sst_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .flush     (soft_clear),
    .in_valid  (wr_dbuf),
    .in_ready  (tx_buf_ready),
    .in_data   (reg_wdata[7:0]),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ****************************************
  // Interrupt requests
  // ****************************************
  assign rx_cond = (rx_done_flag && rx_ready_irq_enable)
                || (modem_status_change_flag && modem_change_irq_enable);
  assign tx_cond = (st.tx_done && st.tx_done_irq_enable)
                || (st.fill_sent_flag && st.underrun_irq_enable);
  // Held until served or the source falls away
  assign rx_irq_req = rx_cond && !st.rx_served;
  assign tx_irq_req = tx_cond && !st.tx_served;

  // Pop only at a tick where the shifter takes a new character
  assign fifo_pop = tx_bit_tick && fifo_valid && st.send
                 && ((st.fsm == sst_pkg::SST_IDLE)
                  || (st.bits_left == `SST_LAST_BIT));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;

    // Register writes
    if (wr_csr) begin
      next_st.tx_done_irq_enable  = reg_wdata[`SST_CSR_TX_IEN];
      next_st.underrun_irq_enable = reg_wdata[`SST_CSR_UND_IEN];
      next_st.send                = reg_wdata[`SST_CSR_SEND];
      next_st.rx_block_on_tx      = reg_wdata[`SST_CSR_RX_BLOCK_ON_TX];
      next_st.brk                 = reg_wdata[`SST_CSR_BREAK];
    end
    if (wr_dbuf) begin
      next_st.tx_data_buffer = reg_wdata[7:0];
      next_st.tx_done        = 1'b0;
    end
    if (reg_wr && (reg_sel == `SST_SEL_SYNC)) begin
      next_st.sync_char = reg_wdata[7:0];
    end
    if (reg_wr && (reg_sel == `SST_SEL_PARAM)) begin
      next_st.char_len = reg_wdata[`SST_PAR_LEN_HI:`SST_PAR_LEN_LO];
      next_st.par_en   = reg_wdata[`SST_PAR_PAR_EN];
      next_st.par_odd  = reg_wdata[`SST_PAR_PAR_ODD];
    end
    // Read clears first; a fill sent in the same cycle sets it again below
    if (rd_csr) begin
      next_st.fill_sent_flag = 1'b0;
    end

    // Serial shifter, advanced only on modem bit ticks
    if (tx_bit_tick) begin
      case (st.fsm)
        sst_pkg::SST_IDLE: begin
          if (fifo_pop) begin
            next_st.fsm       = sst_pkg::SST_SHIFT;
            next_st.shreg     = sst_frame(fifo_data, st.char_len, st.par_en, st.par_odd);
            next_st.bits_left = sst_bits(st.char_len, st.par_en);
            next_st.tx_done   = 1'b1;
          end
        end
        sst_pkg::SST_SHIFT: begin
          if (st.bits_left != `SST_LAST_BIT) begin
            next_st.shreg     = {1'b1, st.shreg[8:1]};
            next_st.bits_left = st.bits_left - 1'b1;
          end else if (!st.send) begin
            // Character done; sync is lost and the line rests at mark
            next_st.fsm   = sst_pkg::SST_IDLE;
            next_st.shreg = '1;
          end else if (fifo_valid) begin
            next_st.shreg     = sst_frame(fifo_data, st.char_len, st.par_en, st.par_odd);
            next_st.bits_left = sst_bits(st.char_len, st.par_en);
            next_st.tx_done   = 1'b1;
          end else begin
            next_st.shreg          = sst_frame(st.sync_char, st.char_len,
                                               st.par_en, st.par_odd);
            next_st.bits_left      = sst_bits(st.char_len, st.par_en);
            next_st.fill_sent_flag = 1'b1;
          end
        end
        default: begin
          next_st.fsm = sst_pkg::SST_IDLE;
        end
      endcase
    end

    // Line level follows the shifter unless break forces space
    if (next_st.brk) begin
      next_st.serial_out = 1'b0;
    end else if (next_st.fsm == sst_pkg::SST_SHIFT) begin
      next_st.serial_out = next_st.shreg[0];
    end else begin
      next_st.serial_out = 1'b1;
    end
    next_st.rx_disable = next_st.rx_block_on_tx && next_st.send;

    // Acknowledge: receiver served ahead of transmitter
    if (irq_ack && rx_irq_req) begin
      next_st.vector    = RX_VECTOR;
      next_st.rx_served = 1'b1;
    end else if (irq_ack && tx_irq_req) begin
      next_st.vector    = TX_VECTOR;
      next_st.tx_served = 1'b1;
    end
    if (!rx_cond) begin
      next_st.rx_served = 1'b0;
    end
    if (!tx_cond) begin
      next_st.tx_served = 1'b0;
    end

    // Read data; data buffer is write-only and reads zero
    next_st.rdata = `SST_WORD_ZERO;
    if (reg_rd) begin
      case (reg_sel)
        `SST_SEL_CSR: begin
          next_st.rdata[`SST_CSR_FILL_SENT] = st.fill_sent_flag;
          next_st.rdata[`SST_CSR_TX_DONE]   = st.tx_done;
          next_st.rdata[`SST_CSR_TX_IEN]    = st.tx_done_irq_enable;
          next_st.rdata[`SST_CSR_UND_IEN]   = st.underrun_irq_enable;
          next_st.rdata[`SST_CSR_SEND]      = st.send;
          next_st.rdata[`SST_CSR_RX_BLOCK_ON_TX]  = st.rx_block_on_tx;
          next_st.rdata[`SST_CSR_BREAK]     = st.brk;
        end
        `SST_SEL_SYNC: begin
          next_st.rdata[7:0] = st.sync_char;
        end
        `SST_SEL_PARAM: begin
          next_st.rdata[`SST_PAR_LEN_HI:`SST_PAR_LEN_LO] = st.char_len;
          next_st.rdata[`SST_PAR_PAR_EN]                 = st.par_en;
          next_st.rdata[`SST_PAR_PAR_ODD]                = st.par_odd;
        end
        default: begin
          next_st.rdata = `SST_WORD_ZERO;
        end
      endcase
    end

    // Software clear returns everything to the reset image
    if (soft_clear) begin
      next_st = RST_ST;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata         = st.rdata;
  assign serial_out        = st.serial_out;
  assign rx_disable        = st.rx_disable;
  assign irq_vector        = st.vector;
  assign bus_request_level = BUS_REQUEST_LEVEL;
endmodule // sst_ctl

/* File: sst_ctl_monitor.sv */
/*
  Port-level checks of the transmitter control block.
  Assumes a bind to sst_ctl with its level and vector parameters.
*/
module sst_ctl_monitor #(
  parameter logic [2:0] BUS_REQUEST_LEVEL = 3'h5,
  parameter logic [7:0] RX_VECTOR         = 8'h30,
  parameter logic [7:0] TX_VECTOR         = 8'h34
) (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [1:0]  reg_sel,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        tx_buf_ready,
  input wire logic        tx_bit_tick,
  input wire logic        serial_out,
  input wire logic        rx_disable,
  input wire logic        rx_done_flag,
  input wire logic        rx_ready_irq_enable,
  input wire logic        modem_status_change_flag,
  input wire logic        modem_change_irq_enable,
  input wire logic        irq_ack,
  input wire logic        rx_irq_req,
  input wire logic        tx_irq_req,
  input wire logic [7:0]  irq_vector,
  input wire logic [2:0]  bus_request_level
);
  // ****************************************
  // Helpers and sequences
  // ****************************************
  logic rx_cond;
  logic csr_wr;
  assign rx_cond = (rx_done_flag && rx_ready_irq_enable) ||
                   (modem_status_change_flag && modem_change_irq_enable);
  assign csr_wr  = reg_wr && reg_sel == 2'h0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_brk_wr;
    csr_wr && reg_wdata[0] && !reg_wdata[8];
  endsequence
  sequence s_rx_ack;
    irq_ack && rx_irq_req;
  endsequence
  sequence s_tx_ack;
    irq_ack && tx_irq_req && !rx_irq_req;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  brk_space_a: assert property (s_brk_wr |-> ##[1:2] !serial_out)
    else $error("line not at space after break set");
  hdx_block_a: assert property (
    csr_wr && reg_wdata[3] && reg_wdata[4] && !reg_wdata[8] |-> ##[1:2] rx_disable)
    else $error("receiver not disabled in half duplex send");
  hdx_free_a: assert property (
    csr_wr && (reg_wdata[8] || !reg_wdata[3] || !reg_wdata[4]) |-> ##[1:2] !rx_disable)
    else $error("receiver disabled outside half duplex send");
  rx_quiet_a: assert property (!rx_cond |-> !rx_irq_req)
    else $error("receiver request without a source");
  rx_raise_a: assert property ($rose(rx_cond) |-> rx_irq_req)
    else $error("receiver request missing");
  rx_first_a: assert property (s_rx_ack |=> irq_vector == RX_VECTOR && !rx_irq_req)
    else $error("receiver vector or request wrong after ack");
  tx_vector_a: assert property (s_tx_ack |=> irq_vector == TX_VECTOR)
    else $error("transmitter vector wrong after ack");
  dbuf_read_a: assert property (reg_rd && reg_sel == 2'h1 |=> reg_rdata == 16'h0000)
    else $error("data buffer readable");
  brl_const_a: assert property (bus_request_level == BUS_REQUEST_LEVEL)
    else $error("bus request level changed");
endmodule // sst_ctl_monitor

/* File: sst_map.svh */
/*
  Register selects, field positions, reset values and fixed counts of the
  synchronous serial transmitter control block.
  Assumes inclusion by bare name from the design.
*/
`ifndef SST_MAP_SVH
`define SST_MAP_SVH

// ****************************************
// Register selects
// ****************************************
`define SST_SEL_CSR       2'h0
`define SST_SEL_DBUF      2'h1
`define SST_SEL_SYNC      2'h2
`define SST_SEL_PARAM     2'h3

// ****************************************
// Control and status fields
// ****************************************
`define SST_CSR_FILL_SENT 15
`define SST_CSR_SOFT_CLR  8
`define SST_CSR_TX_DONE   7
`define SST_CSR_TX_IEN    6
`define SST_CSR_UND_IEN   5
`define SST_CSR_SEND      4
`define SST_CSR_RX_BLOCK_ON_TX  3
`define SST_CSR_BREAK     0

// ****************************************
// Line parameter fields
// ****************************************
`define SST_PAR_LEN_LO    0
`define SST_PAR_LEN_HI    1
`define SST_PAR_PAR_EN    2
`define SST_PAR_PAR_ODD   3

// ****************************************
// Values and counts
// ****************************************
`define SST_BYTE_ONES     8'hFF
`define SST_MIN_CHAR_LEN  4'h5
`define SST_LEN_MAX_CODE  2'h3
`define SST_LAST_BIT      4'h1
`define SST_WORD_ZERO     16'h0000
`define SST_FIFO_DEPTH    8
`define SST_BR_LEVEL      3'h5
`define SST_RX_VECTOR     8'h30
`define SST_TX_VECTOR     8'h34

`endif

/* File: sst_modem.sv */
/*
  Modem model: makes a counted burst of bit ticks and records the line.
  Assumes serial_out settles within two cycles of a tick.
*/
module sst_modem (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [7:0]  count,
  input  wire logic        serial_out,
  output      logic        tx_bit_tick,
  output      logic        busy,
  output      logic [31:0] hist
);
  logic [7:0] left;
  logic [2:0] div;
  assign busy = (left != 8'h00) || tx_bit_tick;
  // Ticks only in bursts, so the bench counts bits exactly
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      left        <= 8'h00;
      div         <= 3'h0;
      tx_bit_tick <= 1'b0;
      hist        <= 32'h0000_0000;
    end else begin
      tx_bit_tick <= 1'b0;
      if (start) begin
        left <= count;
        div  <= 3'h0;
      end else if (left != 8'h00) begin
        if (div == (slow ? 3'h7 : 3'h3)) begin
          div         <= 3'h0;
          tx_bit_tick <= 1'b1;
          left        <= left - 8'h01;
        end else begin
          div <= div + 3'h1;
        end
      end
      // Sample the bit launched by the previous tick, oldest ends lowest
      if (tx_bit_tick) hist <= {serial_out, hist[31:1]};
    end
  end
endmodule // sst_modem

/* File: sst_pkg.sv */
/*
  Types of the synchronous serial transmitter control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sst_pkg;

  // ****************************************
  // Transmitter states
  // ****************************************
  typedef enum logic [0:0] {
    SST_IDLE,
    SST_SHIFT
  } sst_fsm_t;

  // ****************************************
  // Whole state of the control block
  // ****************************************
  typedef struct packed {
    logic        tx_done_irq_enable;
    logic        underrun_irq_enable;
    logic        send;
    logic        rx_block_on_tx;
    logic        brk;
    logic        fill_sent_flag;
    logic        tx_done;
    logic [7:0]  tx_data_buffer;
    logic [7:0]  sync_char;
    logic [1:0]  char_len;
    logic        par_en;
    logic        par_odd;
    sst_fsm_t    fsm;
    logic [8:0]  shreg;
    logic [3:0]  bits_left;
    logic        serial_out;
    logic        rx_disable;
    logic        rx_served;
    logic        tx_served;
    logic [7:0]  vector;
    logic [15:0] rdata;
  } sst_state_t;

endpackage

/* File: sst_tb.sv */
/*
  Self-checking bench of the transmitter control block.
  Assumes the design, the modem model and the monitor are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RXV = 8'h41;
  localparam logic [7:0] TXV = 8'h52;
  logic        sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_ack = 1'b0;
  logic        rx_done_flag = 1'b0, rx_ready_irq_enable = 1'b0;
  logic        modem_status_change_flag = 1'b0, modem_change_irq_enable = 1'b0;
  logic        start = 1'b0, slow = 1'b0, busy, tx_bit_tick, serial_out, tx_buf_ready;
  logic        rx_disable, rx_irq_req, tx_irq_req;
  logic [1:0]  reg_sel = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [7:0]  count = 8'h00;
  logic [7:0]  irq_vector;
  logic [2:0]  bus_request_level;
  logic [31:0] hist;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #4 sys_clk = ~sys_clk;

  sst_ctl #(.RX_VECTOR(RXV), .TX_VECTOR(TXV)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tx_buf_ready(tx_buf_ready), .tx_bit_tick(tx_bit_tick),
    .serial_out(serial_out), .rx_disable(rx_disable), .rx_done_flag(rx_done_flag),
    .rx_ready_irq_enable(rx_ready_irq_enable), .modem_status_change_flag(modem_status_change_flag),
    .modem_change_irq_enable(modem_change_irq_enable), .irq_ack(irq_ack),
    .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req), .irq_vector(irq_vector),
    .bus_request_level(bus_request_level));
  sst_modem mdm (.sys_clk(sys_clk), .arst_n(arst_n), .start(start), .slow(slow),
    .count(count), .serial_out(serial_out), .tx_bit_tick(tx_bit_tick), .busy(busy),
    .hist(hist));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge sys_clk);
    reg_sel   <= s;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] s, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_sel <= s;
    reg_rd  <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(32'(reg_rdata), 32'(exp));
  endtask
  task automatic ack(input logic [7:0] exp);
    @(posedge sys_clk);
    irq_ack <= 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b0;
    #1 chk(32'(irq_vector), 32'(exp));
  endtask
  // Tick burst; slow spacing when asked, bounded by the run ceiling
  task automatic ticks(input logic [7:0] n, input logic s);
    @(posedge sys_clk);
    start <= 1'b1;
    count <= n;
    slow  <= s;
    @(posedge sys_clk);
    start <= 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
    end while (busy !== 1'b0);
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(2'h0, 16'h0080);
    rd(2'h1, 16'h0000);
    wr(2'h0, 16'h0079);
    rd(2'h0, 16'h00F9);
    chk(32'(rx_disable), 32'h1);
    chk(32'(serial_out), 32'h0);
    chk(32'(tx_irq_req), 32'h1);
    chk(32'(bus_request_level), 32'h5);
    @(posedge sys_clk);
    rx_done_flag        <= 1'b1;
    rx_ready_irq_enable <= 1'b1;
    ack(RXV);
    chk(32'(rx_irq_req), 32'h0);
    chk(32'(tx_irq_req), 32'h1);
    ack(TXV);
    chk(32'(tx_irq_req), 32'h0);
    @(posedge sys_clk);
    rx_done_flag <= 1'b0;
    @(posedge sys_clk);
    modem_status_change_flag <= 1'b1;
    modem_change_irq_enable  <= 1'b1;
    @(posedge sys_clk);
    #1 chk(32'(rx_irq_req), 32'h1);
    @(posedge sys_clk);
    modem_status_change_flag <= 1'b0;
    wr(2'h0, 16'h0100);
    rd(2'h0, 16'h0080);
    chk(32'(serial_out), 32'h1);
    chk(32'(rx_disable), 32'h0);
    // Eight bits, even parity; sync loaded before send
    wr(2'h3, 16'h0007);
    wr(2'h2, 16'h0081);
    wr(2'h0, 16'h0030);
    wr(2'h1, 16'h003D);
    rd(2'h0, 16'h0030);
    chk(32'(tx_irq_req), 32'h0);
    ticks(8'd19, 1'b1);
    chk(32'(hist[31:14]), 32'({^8'h81, 8'h81, ^8'h3D, 8'h3D}));
    wr(2'h0, 16'h0030);
    chk(32'(tx_irq_req), 32'h1);
    rd(2'h0, 16'h80B0);
    rd(2'h0, 16'h00B0);
    chk(32'(tx_irq_req), 32'h0);
    // Idle until loaded; send dropped mid-character, done flag left unchecked
    wr(2'h0, 16'h0100);
    wr(2'h2, 16'h0000);
    wr(2'h0, 16'h0010);
    ticks(8'd3, 1'b0);
    wr(2'h1, 16'h0000);
    ticks(8'd4, 1'b0);
    wr(2'h0, 16'h0000);
    ticks(8'd5, 1'b0);
    chk(32'(hist[31:20]), 32'h0000_0E0F);
    // Fill the buffer until refused, then drain; reset sync is the fill
    wr(2'h0, 16'h0100);
    for (int i = 0; i < 8; i++) wr(2'h1, 16'(i + 8'hE0));
    chk(32'(tx_buf_ready), 32'h0);
    wr(2'h1, 16'h00FF);
    wr(2'h0, 16'h0010);
    ticks(8'd42, 1'b0);
    chk(32'(tx_buf_ready), 32'h1);
    chk(32'(hist[31:30]), 32'h2);
    rd(2'h0, 16'h8090);
    // Seven bits, odd parity; masked high bit stays out of parity
    wr(2'h0, 16'h0100);
    wr(2'h3, 16'h000E);
    rd(2'h3, 16'h000E);
    wr(2'h2, 16'h0055);
    rd(2'h2, 16'h0055);
    wr(2'h0, 16'h0010);
    wr(2'h1, 16'h00C3);
    ticks(8'd9, 1'b0);
    chk(32'(hist[31:24]), 32'({~^7'h43, 7'h43}));
    complete_run();
  end
endmodule // tb

bind sst_ctl sst_ctl_monitor #(.BUS_REQUEST_LEVEL(BUS_REQUEST_LEVEL), .RX_VECTOR(RX_VECTOR),
  .TX_VECTOR(TX_VECTOR)) mon (.sys_clk(sys_clk), .arst_n(arst_n), .reg_sel(reg_sel),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .tx_buf_ready(tx_buf_ready), .tx_bit_tick(tx_bit_tick), .serial_out(serial_out),
  .rx_disable(rx_disable), .rx_done_flag(rx_done_flag),
  .rx_ready_irq_enable(rx_ready_irq_enable), .modem_status_change_flag(modem_status_change_flag),
  .modem_change_irq_enable(modem_change_irq_enable), .irq_ack(irq_ack),
  .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req), .irq_vector(irq_vector),
  .bus_request_level(bus_request_level));
